// [rtl/chip_reset_generator.sv]
// chip_reset_generator: power-on reset and power-up clear generation,
// watchdog control word with password check, and the state each reset sets.
// assumes pins are asynchronous levels, synchronised to pclk here; APB slave on one clock.
`timescale 1ns/1ps
`default_nettype none
module chip_reset_generator
    import chip_reset_pkg::*;
#(
    parameter int CLEAR_HOLD = CLEAR_HOLD_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        power_on_det,
    input  wire logic        reset_pin_in,
    input  wire logic        watchdog_expired,
    input  wire logic [15:0] vector_word,
    input  wire logic [7:0]  io_flag_events,
    output var  logic        power_on_reset,
    output var  logic        power_up_clear,
    output var  logic [15:0] vector_addr,
    output var  logic [15:0] pc,
    output var  logic        pc_load,
    output var  logic        cpu_run,
    output var  logic [15:0] cpu_status_word,
    output var  logic        nmi_request,
    output var  logic [7:0]  port_dir,
    output var  logic [7:0]  io_flags,
    output var  logic [4:0]  osc_tap,
    output var  logic [9:0]  freq_mult,
    output var  logic        wdog_timer_mode,
    output var  logic        wdog_clk_aux,
    output var  logic        pin_nmi_mode,
    output var  logic [15:0] timer_cfg
);
    // true when an APB address selects a given register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    logic         pon_s;
    logic         pin_s;
    logic         pin_d_r;
    logic         por_src;
    logic         puc_src;
    logic         wdog_expire_evt;
    logic         nmi_evt;
    logic         pwd_bad_r;
    logic         acc;
    logic         wr_en;
    logic         mapped;
    logic         wdog_wr;
    logic         pw_ok;
    logic [7:0]   wdog_ctrl_r;
    reset_cause_s cause_r;
    seq_state_e   state_r;
    logic [31:0]  rd_nxt;

    // pin and supply detector brought into pclk first; the pin is only read
    bit_sync #(.INIT(1'b0)) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .din     (reset_pin_in),
        .dout    (pin_s)
    );

    bit_sync #(.INIT(1'b1)) u_pon_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .din     (power_on_det),
        .dout    (pon_s)
    );

    // previous synchronised pin level, for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_d_r <= 1'b0;
        end else if (clk_en) begin
            pin_d_r <= pin_s;
        end
    end

    // reset sources; pin low in reset function holds power-on reset,
    // and its return high ends it, so a low-then-high pulse resets
    assign por_src = pon_s | (~pin_nmi_mode & ~pin_s);
    assign wdog_expire_evt = watchdog_expired & ~wdog_timer_mode;
    // watchdog and password only reach the clear, never power-on reset
    assign puc_src = por_src | wdog_expire_evt | pwd_bad_r;
    assign nmi_evt = pin_nmi_mode & pin_d_r & ~pin_s;

    // both resets stay inside: no pin output exists for them
    reset_stretch #(.HOLD(CLEAR_HOLD)) u_por (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .source  (por_src),
        .active  (power_on_reset)
    );

    reset_stretch #(.HOLD(CLEAR_HOLD)) u_puc (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .source  (puc_src),
        .active  (power_up_clear)
    );

    // apb decode; one wait state so prdata always comes from a flop
    assign acc     = psel & penable & pready;
    assign wr_en   = acc & pwrite & clk_en;
    assign mapped  = hit(paddr, OFS_WDOG_CTRL) | hit(paddr, OFS_CAUSE) |
                     hit(paddr, OFS_CLKGEN) | hit(paddr, OFS_PORTS) |
                     hit(paddr, OFS_TIMER) | hit(paddr, OFS_CPU);
    assign wdog_wr = wr_en & hit(paddr, OFS_WDOG_CTRL);
    assign pw_ok   = (pwdata[WDOG_PW_LSB +: 8] == WDOG_PASSWORD);

    // read mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (1'b1)
            hit(paddr, OFS_WDOG_CTRL): rd_nxt = {24'h00_0000, wdog_ctrl_r};
            hit(paddr, OFS_CAUSE):     rd_nxt = {20'h0_0000, state_r,
                                          power_on_reset, power_up_clear,
                                          3'h0, cause_r};
            hit(paddr, OFS_CLKGEN):    rd_nxt = {17'h0_0000, osc_tap, freq_mult};
            hit(paddr, OFS_PORTS):     rd_nxt = {16'h0000, io_flags, port_dir};
            hit(paddr, OFS_TIMER):     rd_nxt = {16'h0000, timer_cfg};
            hit(paddr, OFS_CPU):       rd_nxt = {16'h0000, cpu_status_word};
            default:                   rd_nxt = 32'h0000_0000;
        endcase
    end

    // apb handshake; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata  <= rd_nxt;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // wrong password: one-cycle pulse into the clear, in either mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwd_bad_r <= 1'b0;
        end else if (clk_en) begin
            pwd_bad_r <= wdog_wr & ~pw_ok;
        end
    end

    // watchdog control word; every reset restores watchdog mode on the
    // main clock and hands the pin back to its reset function
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_ctrl_r <= WDOG_CTRL_RST;
        end else if (clk_en) begin
            if (power_up_clear) begin
                wdog_ctrl_r <= WDOG_CTRL_RST;
            end else if (wdog_wr && pw_ok) begin
                wdog_ctrl_r <= pwdata[7:0];
            end
        end
    end

    // mode bits as registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_nmi_mode    <= 1'b0;
            wdog_timer_mode <= 1'b0;
            wdog_clk_aux    <= 1'b0;
        end else if (clk_en) begin
            if (power_up_clear) begin
                pin_nmi_mode    <= 1'b0;
                wdog_timer_mode <= 1'b0;
                wdog_clk_aux    <= 1'b0;
            end else if (wdog_wr && pw_ok) begin
                pin_nmi_mode    <= pwdata[WDOG_NMI_SEL_BIT];
                wdog_timer_mode <= pwdata[WDOG_TIMER_BIT];
                wdog_clk_aux    <= pwdata[WDOG_CLKSRC_BIT];
            end
        end
    end

    // nmi pulse per pin event, independent of the global interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_request <= 1'b0;
        end else if (clk_en) begin
            nmi_request <= nmi_evt;
        end
    end

    // reset cause record; survives the clear so software can read it,
    // write one to clear, a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= '0;
        end else if (clk_en) begin
            if (wr_en && hit(paddr, OFS_CAUSE)) begin
                cause_r <= cause_r & ~reset_cause_s'(pwdata[4:0]);
            end
            if (pon_s) cause_r.power_on <= 1'b1;
            if (~pin_nmi_mode & ~pin_s) cause_r.pin_reset <= 1'b1;
            if (wdog_expire_evt) cause_r.wdog_expiry <= 1'b1;
            if (pwd_bad_r) cause_r.password <= 1'b1;
            if (nmi_evt) cause_r.nmi <= 1'b1;
        end
    end

    // ports to input, io flags cleared; flags set by their events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_dir <= PORT_DIR_RST;
            io_flags <= IO_FLAGS_RST;
        end else if (clk_en) begin
            if (power_up_clear) begin
                port_dir <= PORT_DIR_RST;
                io_flags <= IO_FLAGS_RST;
            end else begin
                if (wr_en && hit(paddr, OFS_PORTS)) begin
                    port_dir <= pwdata[7:0];
                    io_flags <= (io_flags & ~pwdata[15:8]) | io_flag_events;
                end else begin
                    io_flags <= io_flags | io_flag_events;
                end
            end
        end
    end

    // clock generator: lowest tap so a bad setting is not kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_tap   <= OSC_TAP_RST;
            freq_mult <= FREQ_MULT_RST;
        end else if (clk_en) begin
            if (power_up_clear) begin
                osc_tap   <= OSC_TAP_RST;
                freq_mult <= FREQ_MULT_RST;
            end else if (wr_en && hit(paddr, OFS_CLKGEN)) begin
                osc_tap   <= pwdata[14:10];
                freq_mult <= pwdata[9:0];
            end
        end
    end

    // timer bits: only power-on reset and apb writes touch them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_cfg <= TIMER_CFG_RST;
        end else if (clk_en) begin
            if (power_on_reset) begin
                timer_cfg <= TIMER_CFG_RST;
            end else if (wr_en && hit(paddr, OFS_TIMER)) begin
                timer_cfg <= pwdata[15:0];
            end
        end
    end

    // cpu status word; zero means active, interrupts off, loop on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_status_word <= CPU_STATUS_RST;
        end else if (clk_en) begin
            if (power_up_clear) begin
                cpu_status_word <= CPU_STATUS_RST;
            end else if (wr_en && hit(paddr, OFS_CPU)) begin
                cpu_status_word <= pwdata[15:0];
            end
        end
    end

    // start sequence: fetch vector, then wait for the pin to be high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= ST_RESET;
            pc          <= 16'h0000;
            pc_load     <= 1'b0;
            cpu_run     <= 1'b0;
            vector_addr <= RESET_VECTOR_ADDR;
        end else if (clk_en) begin
            pc_load     <= 1'b0;
            vector_addr <= RESET_VECTOR_ADDR;
            if (power_up_clear) begin
                state_r <= ST_RESET;
                cpu_run <= 1'b0;
            end else begin
                unique case (state_r)
                    ST_RESET: state_r <= ST_LOAD;
                    ST_LOAD: begin
                        pc      <= vector_word;
                        pc_load <= 1'b1;
                        state_r <= ST_WAIT_PIN;
                    end
                    ST_WAIT_PIN: begin
                        if (pin_s) begin
                            cpu_run <= 1'b1;
                            state_r <= ST_RUN;
                        end
                    end
                    ST_RUN: state_r <= ST_RUN;
                endcase
            end
        end
    end

    // checks
    AST_POR_GIVES_CLEAR: assert property (@(posedge pclk)
        disable iff (!presetn) power_on_reset |-> power_up_clear)
        else $error("power-on reset without power-up clear");

    AST_WDOG_NO_POR: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !power_on_reset && !por_src && !pon_s && pin_s
         && wdog_expire_evt) |=> !power_on_reset)
        else $error("watchdog expiry raised power-on reset");

    AST_WDOG_EXPIRY: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && watchdog_expired && !wdog_timer_mode)
        |=> power_up_clear)
        else $error("watchdog expiry did not raise the clear");

    AST_PASSWORD: assert property (@(posedge pclk) disable iff (!presetn)
        (wdog_wr && !pw_ok) |=> ##1 power_up_clear || !clk_en)
        else $error("bad password did not raise the clear");

    AST_PORTS_CLEARED: assert property (@(posedge pclk)
        disable iff (!presetn) (clk_en && power_up_clear)
        |=> (port_dir == PORT_DIR_RST && io_flags == IO_FLAGS_RST))
        else $error("ports not reset by the clear");

    AST_CPU_CLK_DEFAULTS: assert property (@(posedge pclk)
        disable iff (!presetn) (clk_en && power_up_clear)
        |=> (cpu_status_word == CPU_STATUS_RST && osc_tap == OSC_TAP_RST
             && freq_mult == FREQ_MULT_RST && !pin_nmi_mode
             && !wdog_timer_mode))
        else $error("cpu or clock defaults not applied");

    AST_TIMER_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && power_up_clear && !power_on_reset && !wr_en)
        |=> $stable(timer_cfg))
        else $error("timer bits changed by the clear alone");

    AST_PC_FROM_VECTOR: assert property (@(posedge pclk)
        disable iff (!presetn) pc_load |-> (pc == $past(vector_word)
        && vector_addr == RESET_VECTOR_ADDR))
        else $error("pc not loaded from reset vector");

    AST_RUN_AFTER_PIN: assert property (@(posedge pclk)
        disable iff (!presetn) $rose(cpu_run) |-> $past(pin_s))
        else $error("cpu started while pin low");

    AST_NMI_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && nmi_evt) |=> nmi_request)
        else $error("pin event in nmi mode gave no request");

    CV_WDOG_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
        wdog_expire_evt ##[1:4] power_up_clear);
    CV_NMI: cover property (@(posedge pclk) disable iff (!presetn)
        nmi_request);
    CV_START: cover property (@(posedge pclk) disable iff (!presetn)
        pc_load ##[1:20] cpu_run);
endmodule : chip_reset_generator
`default_nettype wire

// [rtl/chip_reset_pkg.sv]
// chip_reset_pkg: offsets, field positions, reset values and types of the
// reset generator.
// assumes one 125 MHz clock domain and an APB register port.
package chip_reset_pkg;

    // register byte offsets on the APB port
    localparam logic [7:0] OFS_WDOG_CTRL = 8'h00;
    localparam logic [7:0] OFS_CAUSE     = 8'h04;
    localparam logic [7:0] OFS_CLKGEN    = 8'h08;
    localparam logic [7:0] OFS_PORTS     = 8'h0c;
    localparam logic [7:0] OFS_TIMER     = 8'h10;
    localparam logic [7:0] OFS_CPU       = 8'h14;

    // watchdog control word layout
    localparam int         WDOG_CLKSRC_BIT  = 3;
    localparam int         WDOG_TIMER_BIT   = 4;
    localparam int         WDOG_NMI_SEL_BIT = 5;
    localparam int         WDOG_PW_LSB      = 8;
    localparam logic [7:0] WDOG_PASSWORD    = 8'h5a;
    localparam logic [7:0] WDOG_CTRL_RST    = 8'h00;

    // cpu side values applied on every reset
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
    localparam logic [15:0] CPU_STATUS_RST    = 16'h0000;

    // clock generator defaults
    localparam int         MCLK_TARGET_HZ = 1000000;
    localparam int         ACLK_REF_HZ    = 32768;
    localparam logic [9:0] FREQ_MULT_RST  = 10'(MCLK_TARGET_HZ / ACLK_REF_HZ);
    localparam logic [4:0] OSC_TAP_RST    = 5'h00;

    // port and peripheral defaults
    localparam logic [7:0]  PORT_DIR_RST  = 8'h00;
    localparam logic [7:0]  IO_FLAGS_RST  = 8'h00;
    localparam logic [15:0] TIMER_CFG_RST = 16'h0000;

    // timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int CLEAR_HOLD_NS   = 16;
    localparam int CLEAR_HOLD_CYC  =
        (CLEAR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // sticky record of what caused the last reset
    typedef struct packed {
        logic nmi;
        logic password;
        logic wdog_expiry;
        logic pin_reset;
        logic power_on;
    } reset_cause_s;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_LOAD,
        ST_WAIT_PIN,
        ST_RUN
    } seq_state_e;

endpackage : chip_reset_pkg

// [rtl/bit_sync.sv]
// bit_sync: two-flop synchroniser for slow asynchronous levels.
// assumes the input changes no faster than a few clock periods.
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic din,
    output var  logic dout
);
    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= INIT;
            dout   <= INIT;
        end else if (clk_en) begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : bit_sync
`default_nettype wire

// [rtl/reset_stretch.sv]
// reset_stretch: holds a reset output for HOLD cycles after its source ends.
// assumes a synchronous source level in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module reset_stretch #(
    parameter int HOLD = 2
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic source,
    output var  logic active
);
    localparam int CW = $clog2(HOLD + 1);
    logic [CW-1:0] cnt_r;

    // reload while the source stands, count down after it ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= CW'(HOLD);
            active <= 1'b1;
        end else if (clk_en) begin
            if (source) begin
                cnt_r  <= CW'(HOLD);
                active <= 1'b1;
            end else if (cnt_r != '0) begin
                cnt_r  <= cnt_r - CW'(1);
                active <= 1'b1;
            end else begin
                active <= 1'b0;
            end
        end
    end

    // once raised, the reset lasts at least two enabled cycles
    AST_HOLD_MIN: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(active) && clk_en) |=> active)
        else $error("reset released one cycle after it rose");
endmodule : reset_stretch
`default_nettype wire

// [dv/reset_pin_driver.sv]
// reset_pin_driver: behavioural source for the reset/nmi pin.
// assumes pclk from the bench; one-cycle go strobe starts a low pulse.
`timescale 1ns/1ps
`default_nettype none
module reset_pin_driver #(
    parameter int LOW_CYC = 250
) (
    input  wire logic pclk,
    input  wire logic go,
    output var  logic pin
);
    int cnt = 0;

    // low for 2 us at 125 MHz, otherwise a steady high level
    always @(posedge pclk) begin
        if (go)
            cnt <= LOW_CYC;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end

    // no pull on the pin, so the driver always drives it
    always_comb pin = (cnt == 0);
endmodule : reset_pin_driver
`default_nettype wire

// [dv/testbench.sv]
// testbench: apb task driven checks of the reset generator.
// assumes the pin driver model and a 125 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import chip_reset_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, err;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic power_on_det = 1'b1, watchdog_expired = 1'b0, reset_pin_in;
    logic [7:0] paddr = 8'h00, io_flag_events = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] vector_word = 16'hc000;
    logic pready, pslverr, power_on_reset, power_up_clear, pc_load, cpu_run;
    logic nmi_request, wdog_timer_mode, wdog_clk_aux, pin_nmi_mode;
    logic [15:0] vector_addr, pc, cpu_status_word, timer_cfg;
    logic [7:0] port_dir, io_flags;
    logic [4:0] osc_tap;
    logic [9:0] freq_mult;
    int num_errors = 0, checks = 0, puc_cnt = 0, por_cnt = 0, nmi_cnt = 0;
    int p0, r0, n0, l0, ld_cnt = 0;

    chip_reset_generator #(.CLEAR_HOLD(1)) DUT (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .power_on_det, .reset_pin_in,
        .watchdog_expired, .vector_word, .io_flag_events, .power_on_reset,
        .power_up_clear, .vector_addr, .pc, .pc_load, .cpu_run,
        .cpu_status_word, .nmi_request, .port_dir, .io_flags, .osc_tap,
        .freq_mult, .wdog_timer_mode, .wdog_clk_aux, .pin_nmi_mode,
        .timer_cfg);

    reset_pin_driver pin_drv (.pclk(pclk), .go(go), .pin(reset_pin_in));

    initial begin
        forever #4 pclk = ~pclk;
    end

    // cycle counts of each reset and of nmi pulses
    always @(posedge pclk) begin
        puc_cnt <= puc_cnt + int'(power_up_clear === 1'b1);
        por_cnt <= por_cnt + int'(power_on_reset === 1'b1);
        nmi_cnt <= nmi_cnt + int'(nmi_request === 1'b1);
        ld_cnt  <= ld_cnt + int'(pc_load === 1'b1);
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(32'(n < 50), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for the cpu to be released again
    task wait_run();
        int n;
        n = 0;
        repeat (4) @(posedge pclk);
        while (cpu_run !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n < 1000), 32'h1);
    endtask : wait_run

    // one-cycle strobe on the pin driver's go or on the watchdog expiry;
    // driven here directly, a copied-out argument would never reach the pin
    task pulse(input bit pin_src);
        @(posedge pclk);
        if (pin_src)
            go <= 1'b1;
        else
            watchdog_expired <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        watchdog_expired <= 1'b0;
    endtask : pulse

    task final_report();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // hang guard at 25000 cycles, far beyond the several hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        power_on_det <= 1'b0;
        wait_run();
        chk(32'(pc), 32'hc000);
        chk(32'(vector_addr), 32'hfffe);
        apb(1'b0, OFS_CLKGEN, 32'h0);
        chk(rd, 32'(MCLK_TARGET_HZ / ACLK_REF_HZ));
        apb(1'b0, OFS_CPU, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_WDOG_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_PORTS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test reset_values done");
        // watchdog expiry in watchdog mode: clear only
        apb(1'b1, OFS_TIMER, 32'h1234);
        apb(1'b1, OFS_PORTS, 32'h00ff);
        apb(1'b1, OFS_CPU, 32'h0018);
        // io flag events set flags that the clear must drop
        @(posedge pclk);
        io_flag_events <= 8'h81;
        @(posedge pclk);
        io_flag_events <= 8'h00;
        apb(1'b0, OFS_PORTS, 32'h0);
        chk(rd, 32'h81ff);
        p0 = puc_cnt;
        r0 = por_cnt;
        l0 = ld_cnt;
        pulse(1'b0);
        wait_run();
        chk(32'(puc_cnt > p0), 32'h1);
        chk(32'(por_cnt), 32'(r0));
        chk(32'(ld_cnt - l0), 32'h1);
        apb(1'b0, OFS_TIMER, 32'h0);
        chk(rd, 32'h1234);
        apb(1'b0, OFS_PORTS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_CPU, 32'h0);
        chk(rd, 32'h0);
        $display("test watchdog_expiry done");
        // timer mode ignores expiry, wrong password still clears
        apb(1'b1, OFS_WDOG_CTRL, 32'h5a18);
        @(posedge pclk);
        chk(32'({wdog_timer_mode, wdog_clk_aux}), 32'h3);
        p0 = puc_cnt;
        pulse(1'b0);
        repeat (10) @(posedge pclk);
        chk(32'(puc_cnt), 32'(p0));
        r0 = por_cnt;
        apb(1'b1, OFS_WDOG_CTRL, 32'h3310);
        wait_run();
        chk(32'(puc_cnt > p0), 32'h1);
        chk(32'(por_cnt), 32'(r0));
        chk(32'({wdog_timer_mode, wdog_clk_aux}), 32'h0);
        apb(1'b0, OFS_WDOG_CTRL, 32'h0);
        chk(rd, 32'h0);
        $display("test password done");
        // pin pulse in reset function: full power-on reset
        p0 = puc_cnt;
        r0 = por_cnt;
        pulse(1'b1);
        repeat (100) @(posedge pclk);
        chk(32'(cpu_run), 32'h0);
        wait_run();
        chk(32'(por_cnt > r0), 32'h1);
        chk(32'(puc_cnt - p0 >= por_cnt - r0), 32'h1);
        apb(1'b0, OFS_TIMER, 32'h0);
        chk(rd, 32'h0);
        $display("test pin_reset done");
        // nmi function: one request, no reset, then back to reset function
        apb(1'b1, OFS_WDOG_CTRL, 32'h5a20);
        r0 = por_cnt;
        n0 = nmi_cnt;
        pulse(1'b1);
        repeat (300) @(posedge pclk);
        chk(32'(nmi_cnt - n0), 32'h1);
        chk(32'(por_cnt), 32'(r0));
        apb(1'b1, OFS_WDOG_CTRL, 32'h0020);
        wait_run();
        chk(32'(pin_nmi_mode), 32'h0);
        $display("test nmi done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
